// ### core/rec_pkg.sv
// Constants, types and helpers shared by the error containment block
// Behaviour
// - Errors consumed during translation end the transaction by abort or error return.
// - Consumed errors are reported in the error record, besides containment.
// - Queue writes carrying an error leave flagged as poisoned.
// - A cache entry error on a client request terminates that request.
// - A register error on a client request terminates that request and is recorded.
// - With reporting on, errors go to the record; otherwise they abort.
// - Fault events go to the queue of the transaction's security state.
// - Walk, stream entry and context fetch errors raise their own fault events.
// - Command fetch error sets command queue flag and fetch abort code.
// - Page request queue abort sets its global error flag.
// - Event queue abort sets its global error flag.
// - Loss of internal consistency enters the failure state.
// - In failure state all client requests abort and queue access stops.
// - Registers stay readable in the failure state.
// - Reset always leaves failure state; a software exit also exists.
// - Failure entry sets the failure flag in both global error registers.
// - Failure entry writes a syndrome and raises the recovery interrupt.
// - At least one memory-mapped error record group exists.
// - Error recovery and fault handling interrupt outputs exist.
// - The error record is reachable without a secure attribute.
package rec_pkg;
	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [11:0] OFS_GERR_NS   = 12'h000;
	localparam logic [11:0] OFS_GERR_S    = 12'h004;
	localparam logic [11:0] OFS_CONS_NS   = 12'h008;
	localparam logic [11:0] OFS_CONS_S    = 12'h00C;
	localparam logic [11:0] OFS_CTRL      = 12'h010;
	localparam logic [11:0] OFS_ERR_STAT  = 12'h014;
	localparam int          GERR_W        = 9;
	localparam int          GE_CMDQ       = 0;
	localparam int          GE_EVTQ_ABT   = 2;
	localparam int          GE_PRIQ_ABT   = 3;
	localparam int          GE_FAIL       = 8;
	localparam int          CONS_LSB      = 24;
	localparam int          CONS_W        = 7;
	localparam logic [6:0]  CMD_FETCH_ABORT_CODE = 7'h02;
	localparam int          CTRL_RAS_EN   = 0;
	localparam int          CTRL_ERR_RET  = 1;
	localparam int          CTRL_EXIT     = 2;
	localparam logic [1:0]  CTRL_RST      = 2'h1;
	localparam int          ST_SYND_LSB   = 4;
	localparam int          ST_CNT_LSB    = 16;
	// ------------------------------------------------------------
	// Event and syndrome codes
	// ------------------------------------------------------------
	localparam logic [7:0]  EVT_WALK_ABORT = 8'h01;
	localparam logic [7:0]  EVT_STE_FETCH  = 8'h02;
	localparam logic [7:0]  EVT_CD_FETCH   = 8'h03;
	localparam logic [3:0]  SYN_CLIENT     = 4'h1;
	localparam logic [3:0]  SYN_FETCH      = 4'h2;
	localparam logic [3:0]  SYN_QUEUE      = 4'h3;
	localparam logic [3:0]  SYN_FAIL       = 4'hF;
	typedef enum logic [1:0] {FK_WALK, FK_STE, FK_CD} rec_fetch_t;
	typedef enum logic {REC_RUN, REC_FAIL} rec_mode_t;
	// Set beats clear so an event in the clearing cycle survives
	function automatic logic [GERR_W-1:0] gerr_update(
		input logic [GERR_W-1:0] cur,
		input logic [GERR_W-1:0] set,
		input logic [GERR_W-1:0] clr);
		gerr_update = (cur & ~clr) | set;
	endfunction : gerr_update
endpackage : rec_pkg

// ### core/rec_evt_gen.sv
// Fault event generator for consumed fetch errors
`timescale 1ns/1ns
`default_nettype none
module rec_evt_gen
	import rec_pkg::*;
(
	input  wire logic       clk_i,       // Clock
	input  wire logic       rst_i,       // Sync reset
	input  wire logic       ce_i,        // Clock enable
	input  wire logic       en_i,        // Queue access allowed
	input  wire logic       ue_i,        // Fetch consumed error
	input  wire logic [1:0] kind_i,      // Fetch kind
	input  wire logic       sec_i,       // Security state
	output logic            evt_valid_o, // Event pulse
	output logic [7:0]      evt_code_o,  // Event code
	output logic            evt_sec_o    // Target queue
);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			evt_valid_o <= 1'b0;
			evt_code_o  <= 8'h00;
			evt_sec_o   <= 1'b0;
		end else if (ce_i) begin
			evt_valid_o <= 1'b0;
			evt_sec_o   <= sec_i;
			if (en_i && ue_i) begin
				evt_valid_o <= 1'b1;
				unique case (rec_fetch_t'(kind_i))
					FK_WALK: evt_code_o <= EVT_WALK_ABORT;
					FK_STE:  evt_code_o <= EVT_STE_FETCH;
					FK_CD:   evt_code_o <= EVT_CD_FETCH;
					default: evt_valid_o <= 1'b0;
				endcase
			end
		end
	end
endmodule : rec_evt_gen
`default_nettype wire

// ### core/rec_err_rec.sv
// Error record group with its two interrupt outputs
`timescale 1ns/1ns
`default_nettype none
module rec_err_rec
	import rec_pkg::*;
(
	input  wire logic        clk_i,   // Clock
	input  wire logic        rst_i,   // Sync reset
	input  wire logic        ce_i,    // Clock enable
	input  wire logic        log_i,   // Record an error
	input  wire logic [3:0]  synd_i,  // Syndrome of it
	input  wire logic        clr_i,   // Software clear
	output logic             valid_o, // Record valid
	output logic [3:0]       synd_o,  // Latest syndrome
	output logic [15:0]      count_o, // Errors seen
	output logic             eri_o,   // Error recovery irq
	output logic             fhi_o    // Fault handling irq
);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			valid_o <= 1'b0;
			synd_o  <= 4'h0;
			count_o <= 16'h0000;
			eri_o   <= 1'b0;
			fhi_o   <= 1'b0;
		end else if (ce_i) begin
			if (log_i) begin
				valid_o <= 1'b1;
				synd_o  <= synd_i;
				if (count_o != 16'hFFFF)
					count_o <= count_o + 16'h0001;
				eri_o   <= 1'b1;
				fhi_o   <= 1'b1;
			end else if (clr_i) begin
				valid_o <= 1'b0;
				eri_o   <= 1'b0;
				fhi_o   <= 1'b0;
			end
		end
	end
endmodule : rec_err_rec
`default_nettype wire

// ### core/rec_ras_containment.sv
// Error containment, global error flags and failure state of the translation unit
`timescale 1ns/1ns
`default_nettype none
module rec_ras_containment
	import rec_pkg::*;
(
	input  wire logic        clk_i,            // Clock, 125 MHz
	input  wire logic        rst_i,            // Sync reset, high
	input  wire logic        ce_i,             // Clock enable
	input  wire logic        wb_cyc_i,         // Bus cycle
	input  wire logic        wb_stb_i,         // Bus strobe
	input  wire logic        wb_we_i,          // Write
	input  wire logic [11:0] wb_adr_i,         // Byte address
	input  wire logic [3:0]  wb_sel_i,         // Byte lanes
	input  wire logic [31:0] wb_dat_i,         // Write data
	output logic [31:0]      wb_dat_o,         // Read data
	output logic             wb_ack_o,         // Acknowledge
	input  wire logic        cli_req_i,        // Client request pulse
	input  wire logic        cli_sec_i,        // Request security state
	input  wire logic        cli_cache_ue_i,   // Cache entry error
	input  wire logic        cli_reg_ue_i,     // Register error
	input  wire logic        cli_fetch_ue_i,   // Fetch error
	input  wire logic [1:0]  cli_fetch_kind_i, // Fetch kind
	output logic             cli_rsp_valid_o,  // Response pulse
	output logic             cli_rsp_abort_o,  // Terminated by abort
	output logic             cli_rsp_err_o,    // Error returned
	input  wire logic        qwr_req_i,        // Queue record write
	input  wire logic        qwr_ue_i,         // Record carries error
	output logic             mem_wr_valid_o,   // Write to memory
	output logic             mem_wr_poison_o,  // Write is poisoned
	output logic             mem_q_en_o,       // Queue access allowed
	input  wire logic        q_sec_i,          // Queue security state
	input  wire logic        cmd_fetch_ue_i,   // Command fetch error
	input  wire logic        prq_abort_i,      // Page request q abort
	input  wire logic        evq_abort_i,      // Event queue abort
	input  wire logic        int_reg_ue_i,     // Queue pointer reg error
	input  wire logic        int_lost_i,       // Consistency lost
	output logic             evt_valid_o,      // Fault event pulse
	output logic [7:0]       evt_code_o,       // Fault event code
	output logic             evt_sec_o,        // Fault event queue
	output logic             err_rec_irq_o,    // Error recovery irq
	output logic             fault_irq_o       // Fault handling irq
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	rec_mode_t          mode;
	logic [GERR_W-1:0]  gerr_ns;
	logic [GERR_W-1:0]  gerr_s;
	logic [CONS_W-1:0]  cons_ns;
	logic [CONS_W-1:0]  cons_s;
	logic [1:0]         ctrl;
	logic               rec_valid;
	logic [3:0]         rec_synd;
	logic [15:0]        rec_count;
	logic               fail;
	logic               enter;
	logic               wr_fire;
	logic [31:0]        wmask;
	logic [31:0]        wbits;
	logic               exit_wr;
	logic               ras_en;
	logic               ue_any;
	logic               ext_err;
	logic               rec_log;
	logic [3:0]         rec_syn;
	logic [GERR_W-1:0]  set_q;
	logic [GERR_W-1:0]  set_ns;
	logic [GERR_W-1:0]  set_s;
	logic [GERR_W-1:0]  clr_ns;
	logic [GERR_W-1:0]  clr_s;

	assign fail    = (mode == REC_FAIL);
	assign enter   = !fail && (int_reg_ue_i || int_lost_i);
	assign wr_fire = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
	assign wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign wbits   = wb_dat_i & wmask;
	assign exit_wr = wr_fire && (wb_adr_i == OFS_CTRL) && wbits[CTRL_EXIT];
	assign ras_en  = ctrl[CTRL_RAS_EN];
	assign ue_any  = cli_cache_ue_i || cli_reg_ue_i || cli_fetch_ue_i;
	assign ext_err = cmd_fetch_ue_i || prq_abort_i || evq_abort_i;

	// ------------------------------------------------------------
	// Failure state
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode <= REC_RUN;
		end else if (ce_i) begin
			unique case (mode)
				REC_RUN:  if (enter) mode <= REC_FAIL;
				REC_FAIL: if (exit_wr) mode <= REC_RUN;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Global error flags, per security state
	// ------------------------------------------------------------
	always_comb begin
		set_q = '0;
		if (!fail) begin
			set_q[GE_CMDQ]     = cmd_fetch_ue_i;
			set_q[GE_PRIQ_ABT] = prq_abort_i;
			set_q[GE_EVTQ_ABT] = evq_abort_i;
		end
		set_ns = q_sec_i ? '0 : set_q;
		set_s  = q_sec_i ? set_q : '0;
		set_ns[GE_FAIL] = enter;
		set_s[GE_FAIL]  = enter;
		// Failure flag clears only on the software exit, not on error flag writes
		clr_ns = '0;
		clr_s  = '0;
		if (wr_fire && wb_adr_i == OFS_GERR_NS)
			clr_ns = wbits[GERR_W-1:0];
		if (wr_fire && wb_adr_i == OFS_GERR_S)
			clr_s = wbits[GERR_W-1:0];
		clr_ns[GE_FAIL] = exit_wr;
		clr_s[GE_FAIL]  = exit_wr;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gerr_ns <= '0;
			gerr_s  <= '0;
		end else if (ce_i) begin
			gerr_ns <= gerr_update(gerr_ns, set_ns, clr_ns);
			gerr_s  <= gerr_update(gerr_s, set_s, clr_s);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cons_ns <= '0;
			cons_s  <= '0;
		end else if (ce_i && !fail && cmd_fetch_ue_i) begin
			if (q_sec_i)
				cons_s <= CMD_FETCH_ABORT_CODE;
			else
				cons_ns <= CMD_FETCH_ABORT_CODE;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			ctrl <= CTRL_RST;
		else if (ce_i && wr_fire && wb_adr_i == OFS_CTRL && wb_sel_i[0])
			ctrl <= wb_dat_i[1:0];
	end

	// ------------------------------------------------------------
	// Client containment
	// ------------------------------------------------------------
	// Without reporting support an error can only be shown as an abort
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cli_rsp_valid_o <= 1'b0;
			cli_rsp_abort_o <= 1'b0;
			cli_rsp_err_o   <= 1'b0;
		end else if (ce_i) begin
			cli_rsp_valid_o <= cli_req_i;
			cli_rsp_abort_o <= cli_req_i && (fail || (ue_any &&
				!(ras_en && ctrl[CTRL_ERR_RET])));
			cli_rsp_err_o   <= cli_req_i && !fail && ue_any &&
				ras_en && ctrl[CTRL_ERR_RET];
		end
	end

	// ------------------------------------------------------------
	// Queue accesses
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mem_wr_valid_o  <= 1'b0;
			mem_wr_poison_o <= 1'b0;
			mem_q_en_o      <= 1'b1;
		end else if (ce_i) begin
			mem_wr_valid_o  <= qwr_req_i && !fail && !enter;
			mem_wr_poison_o <= qwr_req_i && qwr_ue_i && !fail && !enter;
			mem_q_en_o      <= !(fail || enter) || exit_wr;
		end
	end

	rec_evt_gen u_evt (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.ce_i        (ce_i),
		.en_i        (!fail && !enter),
		.ue_i        (cli_req_i && cli_fetch_ue_i),
		.kind_i      (cli_fetch_kind_i),
		.sec_i       (cli_sec_i),
		.evt_valid_o (evt_valid_o),
		.evt_code_o  (evt_code_o),
		.evt_sec_o   (evt_sec_o)
	);

	// ------------------------------------------------------------
	// Error record
	// ------------------------------------------------------------
	always_comb begin
		rec_syn = SYN_CLIENT;
		if (enter)
			rec_syn = SYN_FAIL;
		else if (ext_err)
			rec_syn = SYN_QUEUE;
		else if (cli_fetch_ue_i)
			rec_syn = SYN_FETCH;
		rec_log = enter || (ras_en && !fail &&
			(ext_err || (cli_req_i && ue_any)));
	end

	rec_err_rec u_rec (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.ce_i    (ce_i),
		.log_i   (rec_log),
		.synd_i  (rec_syn),
		.clr_i   (wr_fire && wb_adr_i == OFS_ERR_STAT && wbits[0]),
		.valid_o (rec_valid),
		.synd_o  (rec_synd),
		.count_o (rec_count),
		.eri_o   (err_rec_irq_o),
		.fhi_o   (fault_irq_o)
	);

	// ------------------------------------------------------------
	// Bus slave: one wait state, unmapped reads return zero
	// ------------------------------------------------------------
	// Decode ignores the security attribute, so every master reaches it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else if (ce_i) begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
			wb_dat_o <= 32'h0000_0000;
			if (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o) begin
				unique case (wb_adr_i)
					OFS_GERR_NS:  wb_dat_o[GERR_W-1:0] <= gerr_ns;
					OFS_GERR_S:   wb_dat_o[GERR_W-1:0] <= gerr_s;
					OFS_CONS_NS:  wb_dat_o[CONS_LSB +: CONS_W] <= cons_ns;
					OFS_CONS_S:   wb_dat_o[CONS_LSB +: CONS_W] <= cons_s;
					OFS_CTRL:     wb_dat_o[2:0] <= {fail, ctrl};
					OFS_ERR_STAT: begin
						wb_dat_o[0] <= rec_valid;
						wb_dat_o[ST_SYND_LSB +: 4] <= rec_synd;
						wb_dat_o[ST_CNT_LSB +: 16] <= rec_count;
					end
					default:      wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	cache_ue_kill_a: assert property (ce_i && cli_req_i && cli_cache_ue_i
		|=> cli_rsp_valid_o && (cli_rsp_abort_o || cli_rsp_err_o))
		else $error("cache error request not terminated");
	fail_abort_a: assert property (ce_i && fail && cli_req_i
		|=> cli_rsp_abort_o && !cli_rsp_err_o)
		else $error("request passed in failure state");
	fail_qstop_a: assert property (ce_i && fail ##1 ce_i && fail && !exit_wr
		|=> !mem_wr_valid_o && !mem_q_en_o)
		else $error("queue accessed in failure state");
	fail_hold_a: assert property (ce_i && fail && !exit_wr |=> fail)
		else $error("failure state left without exit");
	fail_flags_a: assert property (ce_i && enter
		|=> fail && gerr_ns[GE_FAIL] && gerr_s[GE_FAIL] && err_rec_irq_o)
		else $error("failure entry not signalled");
	cmdq_flag_a: assert property (ce_i && !fail && cmd_fetch_ue_i && !q_sec_i
		|=> gerr_ns[GE_CMDQ] && cons_ns == CMD_FETCH_ABORT_CODE)
		else $error("command fetch error not flagged");
	prq_flag_a: assert property (ce_i && !fail && prq_abort_i && q_sec_i
		|=> gerr_s[GE_PRIQ_ABT])
		else $error("page request abort not flagged");
	evq_flag_a: assert property (ce_i && !fail && evq_abort_i && !q_sec_i
		|=> gerr_ns[GE_EVTQ_ABT])
		else $error("event queue abort not flagged");
	poison_wr_a: assert property (ce_i && !fail && !enter && qwr_req_i && qwr_ue_i
		|=> mem_wr_valid_o && mem_wr_poison_o)
		else $error("errored queue write not poisoned");
	walk_evt_a: assert property (ce_i && !fail && !enter && cli_req_i
		&& cli_fetch_ue_i && cli_fetch_kind_i == 2'h0
		|=> evt_valid_o && evt_code_o == EVT_WALK_ABORT && evt_sec_o == $past(cli_sec_i))
		else $error("walk fault event missing");
	bus_ack_a: assert property (ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o
		|=> wb_ack_o)
		else $error("bus access not acknowledged");

	fail_entry_c: cover property (ce_i && enter ##1 fail);
	poison_c: cover property (mem_wr_poison_o);
	err_return_c: cover property (cli_rsp_err_o);
	exit_c: cover property (fail ##1 ce_i && exit_wr ##1 !fail);
endmodule : rec_ras_containment
`default_nettype wire

// ### verif/rec_mem_model.sv
// Memory-side model that takes queue record writes from the block
`timescale 1ns/1ns
`default_nettype none
module rec_mem_model (
	input  wire logic   clk_i,        // Clock
	input  wire logic   rst_i,        // Sync reset
	input  wire logic   wr_valid_i,   // Record write
	input  wire logic   poison_i,     // Write carries error
	input  wire logic   q_en_i,       // Queue access allowed
	output logic [15:0] wr_cnt_o,     // Writes taken
	output logic [15:0] poison_cnt_o, // Locations poisoned
	output logic [15:0] stray_cnt_o   // Writes while stopped
);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_cnt_o     <= 16'h0;
			poison_cnt_o <= 16'h0;
			stray_cnt_o  <= 16'h0;
		end else begin
			if (wr_valid_i) wr_cnt_o <= wr_cnt_o + 16'h1;
			// Writes that carry the poison flag are counted so the bench can check them
			if (wr_valid_i && poison_i) poison_cnt_o <= poison_cnt_o + 16'h1;
			// A write after queue access stopped would land silently
			if (wr_valid_i && !q_en_i) stray_cnt_o <= stray_cnt_o + 16'h1;
		end
	end
endmodule : rec_mem_model
`default_nettype wire

// ### verif/test_ras_error_containment.sv
// Self-checking bench for the error containment block
`timescale 1ns/1ns
`default_nettype none
module test_ras_error_containment
	import rec_pkg::*;
;
	logic        clk_i = 1'h0;
	logic        rst_i = 1'h1;
	logic        cyc = 1'h0, stb = 1'h0, we = 1'h0, ack;
	logic [11:0] adr = 12'h0;
	logic [31:0] wdat = 32'h0, rdat;
	logic        req = 1'h0, sec = 1'h0, cue = 1'h0, rue = 1'h0, fue = 1'h0;
	logic [1:0]  kind = 2'h0;
	logic        qwr = 1'h0, que = 1'h0, qsec = 1'h0;
	logic [4:0]  ev = 5'h0;
	logic        rv, ra, re, mwv, mwp, qen, evv, evs, eri, fhi;
	logic [7:0]  evc, e_evc, lfsr = 8'h35;
	logic        e_v, e_a, e_e, e_ev, e_evs, e_mv, e_mp, fail_m;
	logic [1:0]  ctrl_m;
	logic [15:0] wr_cnt, poison_cnt, stray_cnt;
	int          mismatches = 0, samples_checked = 0, cycles = 0;

	always #4 clk_i = ~clk_i;

	rec_ras_containment i_rec_ras_containment (
		.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'h1),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.cli_req_i(req), .cli_sec_i(sec), .cli_cache_ue_i(cue),
		.cli_reg_ue_i(rue), .cli_fetch_ue_i(fue), .cli_fetch_kind_i(kind),
		.cli_rsp_valid_o(rv), .cli_rsp_abort_o(ra), .cli_rsp_err_o(re),
		.qwr_req_i(qwr), .qwr_ue_i(que), .mem_wr_valid_o(mwv),
		.mem_wr_poison_o(mwp), .mem_q_en_o(qen), .q_sec_i(qsec),
		.cmd_fetch_ue_i(ev[0]), .prq_abort_i(ev[1]), .evq_abort_i(ev[2]),
		.int_lost_i(ev[3]), .int_reg_ue_i(ev[4]),
		.evt_valid_o(evv), .evt_code_o(evc), .evt_sec_o(evs),
		.err_rec_irq_o(eri), .fault_irq_o(fhi)
	);

	rec_mem_model i_rec_mem_model (
		.clk_i(clk_i), .rst_i(rst_i), .wr_valid_i(mwv), .poison_i(mwp),
		.q_en_i(qen), .wr_cnt_o(wr_cnt), .poison_cnt_o(poison_cnt),
		.stray_cnt_o(stray_cnt)
	);

	function automatic logic [7:0] next_rand(input logic [7:0] v);
		next_rand = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction : next_rand

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t value %h expected %h", $time, got, exp);
		end
	endtask : chk_reg

	task automatic chk_out(input logic got, input logic exp, input int id);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t output %0d is %b", $time, id, got);
		end
	endtask : chk_out

	// Classic single cycle: hold everything until ack is sampled high
	task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_i);
		cyc  <= 1'h1;
		stb  <= 1'h1;
		we   <= w;
		adr  <= a;
		wdat <= d;
		do @(posedge clk_i); while (ack !== 1'h1);
		q = rdat;
		cyc <= 1'h0;
		stb <= 1'h0;
		we  <= 1'h0;
	endtask : wb

	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
		logic [31:0] q;
		wb(1'h0, a, 32'h0, q);
		chk_reg(q & m, e);
	endtask : rd

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'h1, a, d, q);
	endtask : wr

	task automatic cli(input logic r, input logic s, input logic c, input logic g,
		input logic f, input logic [1:0] k);
		@(posedge clk_i);
		req  <= r;
		sec  <= s;
		cue  <= c;
		rue  <= g;
		fue  <= f;
		kind <= k;
	endtask : cli

	task automatic burst(input int n);
		repeat (n) begin
			lfsr = next_rand(lfsr);
			cli(lfsr[0] | lfsr[1], lfsr[2], lfsr[3] & lfsr[4], lfsr[5] & lfsr[6],
				lfsr[7], lfsr[4:3]);
		end
		cli(1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 2'h0);
	endtask : burst

	task automatic qw(input logic u);
		@(posedge clk_i);
		qwr <= 1'h1;
		que <= u;
		@(posedge clk_i);
		qwr <= 1'h0;
	endtask : qw

	task automatic qe(input int i, input logic s);
		@(posedge clk_i);
		ev[i] <= 1'h1;
		qsec  <= s;
		@(posedge clk_i);
		ev <= 5'h0;
	endtask : qe

	// ------------------------------------------------------------
	// Reference model, compared at every edge
	// ------------------------------------------------------------
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 4000) begin
			mismatches++;
			report_and_stop();
		end
		if (rst_i) begin
			{e_v, e_a, e_e, e_ev, e_mv, e_mp, fail_m} <= 7'h0;
			ctrl_m <= 2'h1;
		end else begin
			chk_out(rv, e_v, 1);
			chk_out(ra, e_a, 2);
			chk_out(re, e_e, 3);
			chk_out(evv, e_ev, 4);
			if (e_ev) chk_reg({24'h0, evc}, {24'h0, e_evc});
			if (e_ev) chk_out(evs, e_evs, 5);
			chk_out(mwv, e_mv, 6);
			chk_out(mwp, e_mp, 7);
			chk_out(qen, ~fail_m, 8);
			e_v   <= req;
			e_a   <= req & (fail_m | ((cue | rue | fue) & (ctrl_m != 2'h3)));
			e_e   <= req & ~fail_m & (cue | rue | fue) & (ctrl_m == 2'h3);
			e_ev  <= req & fue & ~fail_m & (kind != 2'h3);
			e_evc <= {6'h0, kind} + 8'h1;
			e_evs <= sec;
			e_mv  <= qwr & ~fail_m;
			e_mp  <= qwr & que & ~fail_m;
			if (ev[3] | ev[4]) fail_m <= 1'h1;
			if (cyc && stb && we && !ack && adr == OFS_CTRL) begin
				ctrl_m <= wdat[1:0];
				if (wdat[CTRL_EXIT]) fail_m <= 1'h0;
			end
		end
	end

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'h0;
		rd(OFS_CTRL, 32'h1, 32'hFFFFFFFF);
		rd(OFS_GERR_NS, 32'h0, 32'hFFFFFFFF);
		rd(12'h020, 32'h0, 32'hFFFFFFFF);
		burst(60);
		wr(OFS_ERR_STAT, 32'h1);
		cli(1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 2'h0);
		cli(1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 2'h0);
		rd(OFS_ERR_STAT, 32'h11, 32'hFF);
		chk_out(eri, 1'h1, 9);
		chk_out(fhi, 1'h1, 10);
		// Reporting off: consumed errors only abort
		wr(OFS_ERR_STAT, 32'h1);
		wr(OFS_CTRL, 32'h0);
		burst(20);
		rd(OFS_ERR_STAT, 32'h0, 32'h1);
		wr(OFS_CTRL, 32'h3);
		burst(40);
		wr(OFS_CTRL, 32'h1);
		qw(1'h0);
		qw(1'h1);
		qw(1'h1);
		rd(OFS_CTRL, 32'h1, 32'hFFFFFFFF);
		chk_reg({16'h0, wr_cnt}, 32'h3);
		chk_reg({16'h0, poison_cnt}, 32'h2);
		qe(0, 1'h0);
		rd(OFS_GERR_NS, 32'h1, 32'hFFFFFFFF);
		rd(OFS_GERR_S, 32'h0, 32'hFFFFFFFF);
		rd(OFS_CONS_NS, 32'h02000000, 32'h7F000000);
		qe(1, 1'h1);
		rd(OFS_GERR_S, 32'h8, 32'hFFFFFFFF);
		qe(2, 1'h0);
		rd(OFS_GERR_NS, 32'h5, 32'hFFFFFFFF);
		wr(OFS_GERR_NS, 32'h5);
		rd(OFS_GERR_NS, 32'h0, 32'hFFFFFFFF);
		// Failure entry, hold, software exit
		qe(3, 1'h0);
		rd(OFS_GERR_NS, 32'h100, 32'hFFFFFFFF);
		rd(OFS_GERR_S, 32'h108, 32'hFFFFFFFF);
		rd(OFS_CTRL, 32'h5, 32'hFFFFFFFF);
		rd(OFS_ERR_STAT, 32'hF1, 32'hF1);
		burst(20);
		qw(1'h1);
		qe(2, 1'h0);
		wr(OFS_GERR_NS, 32'h1FF);
		rd(OFS_GERR_NS, 32'h100, 32'hFFFFFFFF);
		chk_reg({16'h0, wr_cnt}, 32'h3);
		chk_reg({16'h0, stray_cnt}, 32'h0);
		wr(OFS_CTRL, 32'h5);
		rd(OFS_GERR_NS, 32'h0, 32'hFFFFFFFF);
		// Register error enters failure; reset leaves it
		qe(4, 1'h1);
		rd(OFS_CTRL, 32'h5, 32'hFFFFFFFF);
		@(posedge clk_i);
		rst_i <= 1'h1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'h0;
		rd(OFS_GERR_S, 32'h0, 32'hFFFFFFFF);
		rd(OFS_CTRL, 32'h1, 32'hFFFFFFFF);
		burst(10);
		report_and_stop();
	end
endmodule : test_ras_error_containment
`default_nettype wire
